// File: pcicfg_addr_decoder.sv
`timescale 1ns/1ps
// Summary of operation
// - Claim address register only on DWord access
// - Narrow access to address port forwarded
// - Address register resets to zero
// - Bit 31 enables configuration translation
// - Bus zero: device number picks target
// - Bus zero, other device: type 0
// - Nonzero bus: type 1, bus on AD23:16
// - Device field on AD15:11 for type 1
// - Type 0 decodes at most one select line
// - Bridge is device zero on bus zero
// - Function field driven onto AD10:8
// - Bridge answers internally only function zero
// - Bridge device, nonzero function: unselected type 0
// - Register field driven onto AD7:2
// - Enabled data window accesses become configuration
// - Type 1 low bits 01, rest low
// - Devices above twenty: no select line
module pcicfg_addr_decoder
  import pcicfg_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        resetn,
  input  wire logic        io_valid,
  input  wire logic        io_write,
  input  wire logic [15:0] io_addr,
  input  wire logic [3:0]  io_byte_en,
  input  wire logic [31:0] io_wdata,
  output logic             io_ack,
  output logic [31:0]      io_rdata,
  output logic             io_forward,
  output logic             cfg_req,
  output logic             cfg_internal,
  output logic             cfg_type1,
  output logic             cfg_write,
  output logic [3:0]       cfg_byte_en,
  output logic [31:0]      cfg_ad,
  output logic [5:0]       cfg_reg,
  output logic [31:0]      cfg_wdata,
  output logic             cfg_enable
);
  pcicfg_map_if link();

  pcicfg_addr_store u_store (
    .clk    (clk),
    .resetn (resetn),
    .st     (link.store)
  );

  pcicfg_addr_map u_map (
    .mp (link.map)
  );

  logic hit_addr;
  logic hit_data;
  logic full_dword;
  logic claim_addr;
  logic take_cfg;

  logic        next_io_ack;
  logic [31:0] next_io_rdata;
  logic        next_io_forward;
  logic        next_cfg_req;
  logic        next_cfg_internal;
  logic        next_cfg_type1;
  logic        next_cfg_write;
  logic [3:0]  next_cfg_byte_en;
  logic [31:0] next_cfg_ad;
  logic [5:0]  next_cfg_reg;
  logic [31:0] next_cfg_wdata;
  logic        next_cfg_enable;

  always_comb begin
    hit_addr   = io_valid && (io_addr == PCICFG_ADDR_PORT);
    hit_data   = io_valid && (io_addr[15:2] == PCICFG_DATA_PORT[15:2]);
    full_dword = (io_byte_en == PCICFG_FULL_BE);
    claim_addr = hit_addr && full_dword;
    take_cfg   = hit_data && link.enable;
    link.wr_en   = claim_addr && io_write;
    link.wr_data = io_wdata;
  end

  always_comb begin
    next_io_ack       = claim_addr;
    next_io_rdata     = io_rdata;
    next_io_forward   = io_valid && !claim_addr && !take_cfg;
    next_cfg_req      = take_cfg;
    next_cfg_internal = cfg_internal;
    next_cfg_type1    = cfg_type1;
    next_cfg_write    = cfg_write;
    next_cfg_byte_en  = cfg_byte_en;
    next_cfg_ad       = cfg_ad;
    next_cfg_reg      = cfg_reg;
    next_cfg_wdata    = cfg_wdata;
    next_cfg_enable   = link.enable;
    if (claim_addr && !io_write) begin
      next_io_rdata = link.value;
    end
    if (take_cfg) begin
      next_cfg_internal = link.internal;
      next_cfg_type1    = link.type1;
      next_cfg_write    = io_write;
      next_cfg_byte_en  = io_byte_en;
      next_cfg_ad       = link.ad;
      next_cfg_reg      = link.regn;
      next_cfg_wdata    = io_wdata;
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      io_ack       <= 1'b0;
      io_rdata     <= 32'h0000_0000;
      io_forward   <= 1'b0;
      cfg_req      <= 1'b0;
      cfg_internal <= 1'b0;
      cfg_type1    <= 1'b0;
      cfg_write    <= 1'b0;
      cfg_byte_en  <= 4'h0;
      cfg_ad       <= 32'h0000_0000;
      cfg_reg      <= 6'h00;
      cfg_wdata    <= 32'h0000_0000;
      cfg_enable   <= 1'b0;
    end else begin
      io_ack       <= next_io_ack;
      io_rdata     <= next_io_rdata;
      io_forward   <= next_io_forward;
      cfg_req      <= next_cfg_req;
      cfg_internal <= next_cfg_internal;
      cfg_type1    <= next_cfg_type1;
      cfg_write    <= next_cfg_write;
      cfg_byte_en  <= next_cfg_byte_en;
      cfg_ad       <= next_cfg_ad;
      cfg_reg      <= next_cfg_reg;
      cfg_wdata    <= next_cfg_wdata;
      cfg_enable   <= next_cfg_enable;
    end
  end

  // Checks
  chk_dword_claim: assert property (@(posedge clk) disable iff (!resetn)
    io_valid && io_addr == PCICFG_ADDR_PORT && io_byte_en == PCICFG_FULL_BE |=> io_ack && !io_forward)
    else $error("full dword access to address port not claimed");

  chk_narrow_pass: assert property (@(posedge clk) disable iff (!resetn)
    io_valid && io_addr == PCICFG_ADDR_PORT && io_byte_en != PCICFG_FULL_BE
      |=> io_forward && !io_ack && $stable(link.value))
    else $error("narrow access to address port touched register");

  chk_reset_zero: assert property (@(posedge clk)
    $rose(resetn) |-> link.value == PCICFG_ADDR_RESET && !cfg_enable)
    else $error("address register not zero after reset");

  chk_enable_gate: assert property (@(posedge clk) disable iff (!resetn)
    hit_data && !link.enable |=> !cfg_req && io_forward)
    else $error("data window translated while disabled");

  chk_window_cfg: assert property (@(posedge clk) disable iff (!resetn)
    hit_data && link.enable |=> cfg_req && cfg_ad == $past(link.ad) && cfg_reg == $past(link.regn))
    else $error("enabled data window access not converted");

  chk_type1_layout: assert property (@(posedge clk) disable iff (!resetn)
    cfg_req && cfg_type1 |-> cfg_ad[1:0] == PCICFG_TYPE1_CODE && cfg_ad[31:24] == 8'h00 && cfg_ad[23:16] != 8'h00)
    else $error("type 1 address phase malformed");

  chk_type0_onehot: assert property (@(posedge clk) disable iff (!resetn)
    cfg_req && !cfg_type1 |-> $onehot0(cfg_ad[31:11]) && !cfg_ad[11] && cfg_ad[1:0] == PCICFG_TYPE0_CODE)
    else $error("type 0 select lines malformed");

  chk_high_dev: assert property (@(posedge clk) disable iff (!resetn)
    take_cfg && !link.type1 && link.dev > PCICFG_MAX_SEL_DEV |=> cfg_ad[31:11] == 21'h0 && !cfg_internal)
    else $error("device above twenty got a select line");

  chk_func_abort: assert property (@(posedge clk) disable iff (!resetn)
    take_cfg && !link.type1 && link.dev == PCICFG_BRIDGE_DEV && link.func != PCICFG_BRIDGE_FUNC
      |=> !cfg_internal && cfg_ad[31:11] == 21'h0)
    else $error("bridge nonzero function not sent as unselected type 0");

  chk_low_fields: assert property (@(posedge clk) disable iff (!resetn)
    take_cfg |=> cfg_ad[10:2] == $past(link.value[10:2]))
    else $error("function or register field misplaced");

  chk_reserved_zero: assert property (@(posedge clk) disable iff (!resetn)
    (link.value & ~PCICFG_ADDR_WMASK) == 32'h0)
    else $error("reserved address bits not zero");

  // Address register access
  chk_write_lands: assert property (@(posedge clk) disable iff (!resetn)
    claim_addr && io_write |=> link.value == ($past(io_wdata) & PCICFG_ADDR_WMASK))
    else $error("claimed dword write did not reach the address register");

  chk_read_value: assert property (@(posedge clk) disable iff (!resetn)
    claim_addr && !io_write |=> io_ack && io_rdata == $past(link.value))
    else $error("address register read returned wrong value");

  chk_rdata_hold: assert property (@(posedge clk) disable iff (!resetn)
    !(claim_addr && !io_write) |=> $stable(io_rdata))
    else $error("read data changed without a register read");

  chk_ack_kind: assert property (@(posedge clk) disable iff (!resetn)
    io_ack |-> $past(claim_addr))
    else $error("acknowledge without a claimed dword access");

  chk_value_kept: assert property (@(posedge clk) disable iff (!resetn)
    !(claim_addr && io_write) |=> $stable(link.value))
    else $error("address register changed without a claimed write");

  chk_forward_kept: assert property (@(posedge clk) disable iff (!resetn)
    io_forward |-> $stable(link.value) && !io_ack && !cfg_req)
    else $error("forwarded access touched the address register");

  chk_forward_kind: assert property (@(posedge clk) disable iff (!resetn)
    io_forward |-> $past(io_valid) && !$past(claim_addr))
    else $error("forward pulse without an unclaimed request");

  chk_one_answer: assert property (@(posedge clk) disable iff (!resetn)
    io_valid |=> $onehot({io_ack, io_forward, cfg_req}))
    else $error("request did not get exactly one answer");

  chk_idle_quiet: assert property (@(posedge clk) disable iff (!resetn)
    !io_valid |=> !io_ack && !io_forward && !cfg_req)
    else $error("answer pulse without a request");

  chk_other_port: assert property (@(posedge clk) disable iff (!resetn)
    io_valid && !hit_addr && !hit_data |=> io_forward)
    else $error("access to another port not forwarded");

  chk_reset_outputs: assert property (@(posedge clk)
    $rose(resetn) |-> !io_ack && !io_forward && !cfg_req
      && io_rdata == 32'h0000_0000 && cfg_ad == 32'h0000_0000)
    else $error("outputs not cleared after reset");

  chk_enable_copy: assert property (@(posedge clk) disable iff (!resetn)
    cfg_enable == $past(link.enable))
    else $error("enable copy does not follow bit 31");

  // Translation of data window accesses
  chk_disabled_quiet: assert property (@(posedge clk) disable iff (!resetn)
    !link.enable |=> !cfg_req)
    else $error("configuration request while translation disabled");

  chk_bus_zero: assert property (@(posedge clk) disable iff (!resetn)
    take_cfg && link.bus == PCICFG_LOCAL_BUS |=> cfg_req && !cfg_type1)
    else $error("bus zero access not sent as type 0 or internal");

  chk_type0_code: assert property (@(posedge clk) disable iff (!resetn)
    take_cfg && link.bus == PCICFG_LOCAL_BUS && link.dev != PCICFG_BRIDGE_DEV
      |=> !cfg_internal && cfg_ad[1:0] == PCICFG_TYPE0_CODE)
    else $error("other device on bus zero not sent as type 0");

  chk_type0_low: assert property (@(posedge clk) disable iff (!resetn)
    take_cfg && !link.type1 |=> cfg_ad[10:0] == {$past(link.func), $past(link.regn), PCICFG_TYPE0_CODE})
    else $error("type 0 low address bits wrong");

  chk_type1_bus: assert property (@(posedge clk) disable iff (!resetn)
    take_cfg && link.bus != PCICFG_LOCAL_BUS
      |=> cfg_type1 && !cfg_internal && cfg_ad[23:16] == $past(link.bus))
    else $error("nonzero bus not sent as type 1 with bus number");

  chk_type1_device: assert property (@(posedge clk) disable iff (!resetn)
    take_cfg && link.type1 |=> cfg_ad[15:11] == $past(link.dev))
    else $error("device number not on type 1 address lines");

  chk_select_line: assert property (@(posedge clk) disable iff (!resetn)
    take_cfg && !link.type1 && link.dev != PCICFG_BRIDGE_DEV && link.dev <= PCICFG_MAX_SEL_DEV
      |=> cfg_ad[31:11] == (21'h1 << $past(link.dev)))
    else $error("wrong select line for type 0 device");

  chk_bridge_local: assert property (@(posedge clk) disable iff (!resetn)
    take_cfg && link.bus == PCICFG_LOCAL_BUS && link.dev == PCICFG_BRIDGE_DEV
      && link.func == PCICFG_BRIDGE_FUNC |=> cfg_internal && !cfg_type1)
    else $error("bridge function zero not handled internally");

  chk_func_field: assert property (@(posedge clk) disable iff (!resetn)
    take_cfg |=> cfg_ad[10:8] == $past(link.func))
    else $error("function number not on its address lines");

  chk_internal_only: assert property (@(posedge clk) disable iff (!resetn)
    cfg_req && cfg_internal |-> !cfg_type1 && cfg_ad[31:8] == 24'h00_0000)
    else $error("internal access not for function zero of the bridge");

  chk_reg_field: assert property (@(posedge clk) disable iff (!resetn)
    take_cfg |=> cfg_reg == $past(link.regn) && cfg_ad[7:2] == $past(link.regn))
    else $error("register number not on its address lines");

  chk_window_data: assert property (@(posedge clk) disable iff (!resetn)
    take_cfg |=> cfg_write == $past(io_write) && cfg_byte_en == $past(io_byte_en)
      && cfg_wdata == $past(io_wdata))
    else $error("data window access details not passed on");

  chk_window_bytes: assert property (@(posedge clk) disable iff (!resetn)
    hit_data && link.enable && !full_dword |=> cfg_req && !io_forward)
    else $error("narrow data window access not converted");

  chk_cfg_hold: assert property (@(posedge clk) disable iff (!resetn)
    !take_cfg |=> $stable(cfg_ad) && $stable(cfg_type1) && $stable(cfg_internal) && $stable(cfg_reg))
    else $error("configuration outputs changed without a request");

  chk_type1_word: assert property (@(posedge clk) disable iff (!resetn)
    take_cfg && link.type1 |=> cfg_ad == {8'h00, $past(link.value[23:2]), PCICFG_TYPE1_CODE})
    else $error("type 1 address word wrong");

  chk_high_type0: assert property (@(posedge clk) disable iff (!resetn)
    take_cfg && link.bus == PCICFG_LOCAL_BUS && link.dev > PCICFG_MAX_SEL_DEV
      |=> !cfg_type1 && !cfg_internal && cfg_ad[1:0] == PCICFG_TYPE0_CODE)
    else $error("device above twenty not sent as type 0");
endmodule // pcicfg_addr_decoder

// File: pcicfg_pkg.sv
package pcicfg_pkg;
  // Host I/O locations
  localparam logic [15:0] PCICFG_ADDR_PORT    = 16'h0cf8;
  localparam logic [15:0] PCICFG_DATA_PORT    = 16'h0cfc;
  localparam logic [3:0]  PCICFG_FULL_BE      = 4'hf;
  // Address register layout
  localparam logic [31:0] PCICFG_ADDR_RESET   = 32'h0000_0000;
  localparam logic [31:0] PCICFG_ADDR_WMASK   = 32'h80ff_fffc;
  localparam int          PCICFG_ENABLE_BIT   = 31;
  localparam int          PCICFG_BUS_LSB      = 16;
  localparam int          PCICFG_DEV_LSB      = 11;
  localparam int          PCICFG_FUNC_LSB     = 8;
  localparam int          PCICFG_REG_LSB      = 2;
  // Address phase encoding
  localparam logic [4:0]  PCICFG_BRIDGE_DEV   = 5'h00;
  localparam logic [2:0]  PCICFG_BRIDGE_FUNC  = 3'h0;
  localparam logic [7:0]  PCICFG_LOCAL_BUS    = 8'h00;
  localparam logic [4:0]  PCICFG_MAX_SEL_DEV  = 5'h14;
  localparam int          PCICFG_SEL_BASE     = 11;
  localparam logic [1:0]  PCICFG_TYPE0_CODE   = 2'h0;
  localparam logic [1:0]  PCICFG_TYPE1_CODE   = 2'h1;
endpackage

// File: pcicfg_map_if.sv
`timescale 1ns/1ps
interface pcicfg_map_if;
  logic        wr_en;
  logic [31:0] wr_data;
  logic [31:0] value;
  logic        enable;
  logic [7:0]  bus;
  logic [4:0]  dev;
  logic [2:0]  func;
  logic [5:0]  regn;
  logic [31:0] ad;
  logic        type1;
  logic        internal;
  modport ctrl (output wr_en, output wr_data, input value, input enable, input ad, input type1, input internal,
                input regn);
  modport store (input wr_en, input wr_data, output value, output enable, output bus, output dev, output func,
                 output regn);
  modport map (input bus, input dev, input func, input regn, output ad, output type1, output internal);
endinterface

// File: pcicfg_addr_store.sv
`timescale 1ns/1ps
module pcicfg_addr_store
  import pcicfg_pkg::*;
(
  input  wire logic  clk,
  input  wire logic  resetn,
  pcicfg_map_if.store st
);
  logic [31:0] value;
  logic [31:0] next_value;

  always_comb begin
    next_value = value;
    if (st.wr_en) begin
      next_value = st.wr_data & PCICFG_ADDR_WMASK;
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      value <= PCICFG_ADDR_RESET;
    end else begin
      value <= next_value;
    end
  end

  assign st.value  = value;
  assign st.enable = value[PCICFG_ENABLE_BIT];
  assign st.bus    = value[PCICFG_BUS_LSB +: 8];
  assign st.dev    = value[PCICFG_DEV_LSB +: 5];
  assign st.func   = value[PCICFG_FUNC_LSB +: 3];
  assign st.regn   = value[PCICFG_REG_LSB +: 6];
endmodule // pcicfg_addr_store

// File: pcicfg_addr_map.sv
`timescale 1ns/1ps
module pcicfg_addr_map
  import pcicfg_pkg::*;
(
  pcicfg_map_if.map mp
);
  // One select line per device 1..20; bridge and devices above 20 get none
  function automatic logic [20:0] pcicfg_select(input logic [4:0] dev);
    logic [20:0] sel;
    sel = 21'h0;
    for (int d = 1; d <= 20; d++) begin
      if (dev == 5'(d)) begin
        sel[d] = 1'b1;
      end
    end
    return sel;
  endfunction

  logic is_local;

  always_comb begin
    is_local    = (mp.bus == PCICFG_LOCAL_BUS);
    mp.type1    = !is_local;
    mp.internal = is_local && (mp.dev == PCICFG_BRIDGE_DEV) && (mp.func == PCICFG_BRIDGE_FUNC);
    if (is_local) begin
      mp.ad = {pcicfg_select(mp.dev), mp.func, mp.regn, PCICFG_TYPE0_CODE};
    end else begin
      mp.ad = {8'h00, mp.bus, mp.dev, mp.func, mp.regn, PCICFG_TYPE1_CODE};
    end
  end
endmodule // pcicfg_addr_map

// File: pcicfg_host_model.sv
`timescale 1ns/1ps
module pcicfg_host_model (
  input  wire logic   clk,
  output logic        io_valid,
  output logic        io_write,
  output logic [15:0] io_addr,
  output logic [3:0]  io_byte_en,
  output logic [31:0] io_wdata
);
  initial begin
    io_valid = 1'b0;
    io_write = 1'b0;
    io_addr = 16'h0000;
    io_byte_en = 4'h0;
    io_wdata = 32'h0000_0000;
  end
  // One request per call; idle bus shows the inverse of the last request
  task automatic access(input logic w, input logic [15:0] a, input logic [3:0] be, input logic [31:0] d);
    @(negedge clk);
    io_valid = 1'b1;
    io_write = w;
    io_addr = a;
    io_byte_en = be;
    io_wdata = d;
    @(negedge clk);
    io_valid = 1'b0;
    io_write = ~w;
    io_addr = ~a;
    io_byte_en = ~be;
    io_wdata = ~d;
  endtask
endmodule // pcicfg_host_model

// File: pcicfg_addr_decoder_test.sv
`timescale 1ns/1ps
`define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin n_fail++; \
  $display("unexpected t=%0t got %h exp %h", $time, a, b); end end
module pcicfg_addr_decoder_test;
  import pcicfg_pkg::*;
  logic        clk, resetn, io_valid, io_write, io_ack, io_forward;
  logic        cfg_req, cfg_internal, cfg_type1, cfg_write, cfg_enable;
  logic [15:0] io_addr;
  logic [3:0]  io_byte_en, cfg_byte_en;
  logic [31:0] io_wdata, io_rdata, cfg_ad, cfg_wdata, rnd, w;
  logic [5:0]  cfg_reg;
  logic [4:0]  dev_tab [6] = '{5'h00, 5'h01, 5'h14, 5'h15, 5'h1f, 5'h00};
  int          n_fail, tests_run;
  pcicfg_host_model u_host (.clk(clk), .io_valid(io_valid), .io_write(io_write), .io_addr(io_addr),
    .io_byte_en(io_byte_en), .io_wdata(io_wdata));
  pcicfg_addr_decoder u_dut (.clk(clk), .resetn(resetn), .io_valid(io_valid), .io_write(io_write),
    .io_addr(io_addr), .io_byte_en(io_byte_en), .io_wdata(io_wdata), .io_ack(io_ack), .io_rdata(io_rdata),
    .io_forward(io_forward), .cfg_req(cfg_req), .cfg_internal(cfg_internal), .cfg_type1(cfg_type1),
    .cfg_write(cfg_write), .cfg_byte_en(cfg_byte_en), .cfg_ad(cfg_ad), .cfg_reg(cfg_reg),
    .cfg_wdata(cfg_wdata), .cfg_enable(cfg_enable));
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  function automatic logic [31:0] exp_ad(input logic [31:0] v);
    logic [31:0] ad;
    ad = {21'h0, v[10:2], 2'h0};
    if (v[23:16] != 8'h00) ad = {8'h00, v[23:2], 2'h1};
    else if (v[15:11] != 5'h00 && v[15:11] <= 5'h14) ad[11 + v[15:11]] = 1'b1;
    return ad;
  endfunction
  task automatic complete_run();
    $display("checks %0d mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  initial clk = 1'b0;
  always #20 clk = ~clk;
  initial begin
    #2000000;
    n_fail++;
    complete_run();
  end
  initial begin
    n_fail = 0;
    tests_run = 0;
    resetn = 1'b0;
    rnd = 32'hf97e5e5e;
    repeat (16) @(posedge clk);
    @(negedge clk) resetn = 1'b1;
    u_host.access(1'b0, 16'h0cf8, 4'hf, 32'h0);
    `CHK({io_ack, io_forward, cfg_req, io_rdata}, {3'b100, 32'h0})
    u_host.access(1'b1, 16'h0cf8, 4'h3, 32'hffff_ffff);
    `CHK({io_ack, io_forward, cfg_req}, 3'b010)
    u_host.access(1'b0, 16'h0cfc, 4'hf, 32'h0);
    `CHK({io_ack, io_forward, cfg_req}, 3'b010)
    u_host.access(1'b0, 16'h0cf8, 4'hf, 32'h0);
    `CHK(io_rdata, 32'h0)
    for (int i = 0; i < 40; i++) begin
      rnd = lfsr(rnd);
      w = rnd;
      if (i[0]) w[23:16] = 8'h00;
      if (i < 12) w[15:11] = dev_tab[i >> 1];
      if (i < 12) w[10:8] = i[1] ? 3'h0 : {w[10:9], 1'b1};
      w[31] = (i % 5 != 4);
      u_host.access(1'b1, 16'h0cf8, 4'hf, w);
      `CHK(io_ack, 1'b1)
      u_host.access(1'b0, 16'h0cf8, 4'hf, rnd);
      `CHK(io_rdata, w & 32'h80ff_fffc)
      `CHK(cfg_enable, w[31])
      rnd = lfsr(rnd);
      u_host.access(rnd[0], 16'h0cfc + 16'(rnd[2:1]), rnd[7:4], rnd);
      if (w[31]) begin
        `CHK({io_ack, io_forward, cfg_req}, 3'b001)
        `CHK(cfg_type1, w[23:16] != 8'h00)
        `CHK(cfg_ad, exp_ad(w))
        `CHK(cfg_internal, w[23:8] == 16'h0)
        `CHK({cfg_reg, cfg_write, cfg_byte_en}, {w[7:2], rnd[0], rnd[7:4]})
        if (rnd[0]) `CHK(cfg_wdata, rnd)
      end else `CHK({io_ack, io_forward, cfg_req}, 3'b010)
      u_host.access(rnd[3], rnd[15:0] | 16'h1000, rnd[7:4], rnd);
      `CHK({io_ack, io_forward, cfg_req}, 3'b010)
    end
    u_host.access(1'b1, 16'h0cf8, 4'hf, 32'h80ff_fffc);
    @(negedge clk) resetn = 1'b0;
    @(negedge clk) resetn = 1'b1;
    u_host.access(1'b0, 16'h0cf8, 4'hf, 32'h0);
    `CHK({io_ack, cfg_enable, io_rdata}, {2'b10, PCICFG_ADDR_RESET})
    u_host.access(1'b0, 16'h0cfc, 4'hf, 32'h0);
    `CHK({io_ack, io_forward, cfg_req}, 3'b010)
    complete_run();
  end
endmodule // pcicfg_addr_decoder_test
